/* File: rtl/carkit_id_event_interrupts.sv */
// Purpose: Carkit ID float and resistor conversion interrupt logic
// Assumes: Register port and receive command logic run on link_clk
// Notes:   ID sensing and conversion timing run on clk (25 MHz)
`timescale 1ns/1ps
`default_nettype none

`include "carkit_defines.svh"

// Summary of operation
// R1: Float rise with enable bit0 raises alt_int
// R2: Float fall with enable bit1 raises alt_int
// R3: Link should enable ID pull-up first
// R4: Unimplemented and reserved bits read zero
// R5: Conversion done with enable raises alt_int
// R6: Effective enable ORs both enable bits
// R7: Status bits 5:3 give resistor code
// R8: Done set after 282us conversion
// R9: Only vendor code read clears done
// R10: Latch bit0 on enabled float edges
// R11: Latch bit3 on enabled done rise
// R12: Latch register read returns then clears
// R13: Enable write, set, clear at 1D-1F
// R14: Status register read-only, live state
// R15: alt_int held while enabled latch set
module carkit_id_event_interrupts
   import carkit_pkg::*;
#(
   parameter int unsigned CONV_CYCLES = `CK_CONV_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       link_clk,
   input  wire logic       link_srst,
   input  wire logic       id_pin_open,
   input  wire logic [2:0] id_code_meas,
   input  wire logic [5:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   output logic            reg_hit,
   input  wire logic       conv_start,
   input  wire logic       vendor_rid_irq_en,
   input  wire logic       vendor_code_read,
   output logic            resistor_conv_done,
   output rid_code_t       id_resistor_code,
   output logic            rxcmd_alt_int
);

   // Core clock domain: ID sensing and resistor converter
   logic                 id_open_core;
   logic [2:0]           code_core;
   logic                 start_tgl_core;
   logic                 start_tgl_prev_reg;
   logic                 start_evt;
   conv_state_t          conv_state_reg;
   conv_state_t          conv_state_next;
   logic [`CK_CNT_W-1:0] conv_cnt_reg;
   logic                 conv_end;
   rid_code_t            code_hold_reg;
   logic                 done_tgl_reg;

   // Link clock domain
   logic       start_tgl_reg;
   logic       id_open_state;
   logic       done_tgl_link;
   logic       done_tgl_prev_reg;
   logic       id_open_prev_reg;
   logic       conv_evt;
   logic       float_rise;
   logic       float_fall;
   logic [7:0] carkit_event_enable_reg;
   logic [7:0] carkit_event_enable_next;
   logic [7:0] carkit_event_latch_reg;
   logic [7:0] carkit_event_latch_next;
   logic [7:0] carkit_live_state;
   logic       done_reg;
   logic       done_rise;
   logic       resistor_conv_irq_en;
   logic       id_open_event_latched;
   logic       resistor_conv_event_latched;
   logic       latch_read;
   logic       id_open_rise_en;
   logic       id_open_fall_en;

   // Pin and comparator inputs into the core domain
   bit_sync_2ff #(
      .WIDTH (4)
   ) u_pin_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({id_pin_open, id_code_meas}),
      .q    ({id_open_core, code_core})
   );

   // Start request toggle into the core domain
   bit_sync_2ff #(
      .WIDTH (1)
   ) u_start_sync (
      .clk  (clk),
      .srst (srst),
      .d    (start_tgl_reg),
      .q    (start_tgl_core)
   );

   // Float state and completion toggle into the link domain
   bit_sync_2ff #(
      .WIDTH (2)
   ) u_link_sync (
      .clk  (link_clk),
      .srst (link_srst),
      .d    ({id_open_core, done_tgl_reg}),
      .q    ({id_open_state, done_tgl_link})
   );

   // Start request edge after crossing, busy count end
   assign start_evt = start_tgl_core ^ start_tgl_prev_reg;
   assign conv_end  = (conv_state_reg == CONV_BUSY) &&
                      (conv_cnt_reg == `CK_CNT_W'(CONV_CYCLES - 1));

   // Converter sequencing; a start while busy is ignored
   always_comb begin
      conv_state_next = conv_state_reg;
      case (conv_state_reg)
         CONV_IDLE: begin
            if (start_evt) begin
               conv_state_next = CONV_BUSY;
            end
         end
         CONV_BUSY: begin
            if (conv_end) begin
               conv_state_next = CONV_IDLE;
            end
         end
         default: begin
            conv_state_next = CONV_IDLE;
         end
      endcase
   end

   // Converter state and start request history
   always_ff @(posedge clk) begin
      if (srst) begin
         conv_state_reg     <= CONV_IDLE;
         start_tgl_prev_reg <= 1'b0;
      end else begin
         conv_state_reg     <= conv_state_next;
         start_tgl_prev_reg <= start_tgl_core;
      end
   end

   // R8: conversion time count
   always_ff @(posedge clk) begin
      if (srst) begin
         conv_cnt_reg <= `CK_CNT_ZERO;
      end else if (conv_state_reg != CONV_BUSY) begin
         conv_cnt_reg <= `CK_CNT_ZERO;
      end else begin
         conv_cnt_reg <= conv_cnt_reg + `CK_CNT_ONE;
      end
   end

   // R8: capture code, flag completion
   always_ff @(posedge clk) begin
      if (srst) begin
         code_hold_reg <= RID_0_OHM;
         done_tgl_reg  <= 1'b0;
      end else if (conv_end) begin
         code_hold_reg <= rid_code_t'(code_core);
         done_tgl_reg  <= ~done_tgl_reg;
      end
   end

   // Start requests become a toggle for the crossing
   always_ff @(posedge link_clk) begin
      if (link_srst) begin
         start_tgl_reg <= 1'b0;
      end else if (conv_start) begin
         start_tgl_reg <= ~start_tgl_reg;
      end
   end

   // History for edge detection after crossing
   always_ff @(posedge link_clk) begin
      if (link_srst) begin
         done_tgl_prev_reg <= 1'b0;
         id_open_prev_reg  <= 1'b0;
      end else begin
         done_tgl_prev_reg <= done_tgl_link;
         id_open_prev_reg  <= id_open_state;
      end
   end

   assign conv_evt   = done_tgl_link ^ done_tgl_prev_reg;
   assign float_rise = id_open_state & ~id_open_prev_reg;
   assign float_fall = ~id_open_state & id_open_prev_reg;

   // R7: code copied once the toggle shows it stable
   always_ff @(posedge link_clk) begin
      if (link_srst) begin
         id_resistor_code <= RID_0_OHM;
      end else if (conv_evt) begin
         id_resistor_code <= code_hold_reg;
      end
   end

   // R9: done cleared only by vendor code read; set wins
   always_ff @(posedge link_clk) begin
      if (link_srst) begin
         done_reg <= 1'b0;
      end else if (conv_evt) begin
         done_reg <= 1'b1;
      end else if (vendor_code_read) begin
         done_reg <= 1'b0;
      end
   end

   assign resistor_conv_done = done_reg;
   assign done_rise          = conv_evt & ~done_reg;

   // R6: enable fields, effective conversion enable
   assign id_open_rise_en      = carkit_event_enable_reg[`CK_EN_RISE_BIT];
   assign id_open_fall_en      = carkit_event_enable_reg[`CK_EN_FALL_BIT];
   assign resistor_conv_irq_en = carkit_event_enable_reg[`CK_EN_RID_BIT] | vendor_rid_irq_en;

   // R13: write, set and clear aliases
   always_comb begin
      carkit_event_enable_next = carkit_event_enable_reg;
      if (reg_wr) begin
         case (reg_addr)
            `CK_ADDR_EN_WRITE: begin
               carkit_event_enable_next = reg_wdata;
            end
            `CK_ADDR_EN_SET: begin
               carkit_event_enable_next = carkit_event_enable_reg | reg_wdata;
            end
            `CK_ADDR_EN_CLEAR: begin
               carkit_event_enable_next = carkit_event_enable_reg & ~reg_wdata;
            end
            default: begin
               carkit_event_enable_next = carkit_event_enable_reg;
            end
         endcase
      end
   end

   // R4: only bits 0, 1 and 5 are stored
   always_ff @(posedge link_clk) begin
      if (link_srst) begin
         carkit_event_enable_reg <= `CK_EN_RESET;
      end else begin
         carkit_event_enable_reg <= carkit_event_enable_next & `CK_EN_MASK;
      end
   end

   // R1: rise event needs enable bit0
   // R2: fall event needs enable bit1
   // R10: float edges gated by their enables
   assign id_open_event_latched = (float_rise & id_open_rise_en) |
                                  (float_fall & id_open_fall_en);
   // R5: conversion event feeds alt_int
   // R11: done rise gated by effective enable
   assign resistor_conv_event_latched = done_rise & resistor_conv_irq_en;

   // R12: clear on read, a new event wins over the clear
   assign latch_read = reg_rd && (reg_addr == `CK_ADDR_LATCH);
   always_comb begin
      carkit_event_latch_next = carkit_event_latch_reg;
      if (latch_read) begin
         carkit_event_latch_next = `CK_LT_RESET;
      end
      if (id_open_event_latched) begin
         carkit_event_latch_next[`CK_LT_ID_BIT] = 1'b1;
      end
      if (resistor_conv_event_latched) begin
         carkit_event_latch_next[`CK_LT_RID_BIT] = 1'b1;
      end
   end

   // Latch register
   always_ff @(posedge link_clk) begin
      if (link_srst) begin
         carkit_event_latch_reg <= `CK_LT_RESET;
      end else begin
         carkit_event_latch_reg <= carkit_event_latch_next;
      end
   end

   // R14: live status byte, unimplemented bits zero
   always_comb begin
      carkit_live_state                                   = `CK_BYTE_ZERO;
      carkit_live_state[`CK_ST_OPEN_BIT]                  = id_open_state;
      carkit_live_state[`CK_ST_CODE_MSB:`CK_ST_CODE_LSB]  = id_resistor_code;
      carkit_live_state[`CK_ST_DONE_BIT]                  = done_reg;
   end

   // R4: read mux, unmapped addresses return zero
   always_ff @(posedge link_clk) begin
      if (link_srst) begin
         reg_rdata <= `CK_BYTE_ZERO;
         reg_hit   <= 1'b0;
      end else if (reg_rd) begin
         case (reg_addr)
            `CK_ADDR_EN_WRITE, `CK_ADDR_EN_SET, `CK_ADDR_EN_CLEAR: begin
               reg_rdata <= carkit_event_enable_reg;
               reg_hit   <= 1'b1;
            end
            `CK_ADDR_STATUS: begin
               reg_rdata <= carkit_live_state;
               reg_hit   <= 1'b1;
            end
            `CK_ADDR_LATCH: begin
               reg_rdata <= carkit_event_latch_reg;
               reg_hit   <= 1'b1;
            end
            default: begin
               reg_rdata <= `CK_BYTE_ZERO;
               reg_hit   <= 1'b0;
            end
         endcase
      end else begin
         reg_hit <= 1'b0;
      end
   end

   // R15: alt_int held while an enabled latch bit stands
   always_ff @(posedge link_clk) begin
      if (link_srst) begin
         rxcmd_alt_int <= 1'b0;
      end else begin
         rxcmd_alt_int <=
            (carkit_event_latch_next[`CK_LT_ID_BIT] & (id_open_rise_en | id_open_fall_en)) |
            (carkit_event_latch_next[`CK_LT_RID_BIT] & resistor_conv_irq_en);
      end
   end

endmodule : carkit_id_event_interrupts

`default_nettype wire

/* File: include/carkit_defines.svh */
// Purpose: Constants for the carkit ID event interrupt block
// Assumes: Register addresses are the 6-bit immediate link addresses
// Notes:   Conversion time is held in ns and turned into core clock cycles
`ifndef CARKIT_DEFINES_SVH
`define CARKIT_DEFINES_SVH

// Register addresses
`define CK_ADDR_EN_WRITE  6'h1d
`define CK_ADDR_EN_SET    6'h1e
`define CK_ADDR_EN_CLEAR  6'h1f
`define CK_ADDR_STATUS    6'h20
`define CK_ADDR_LATCH     6'h21

// Enable register fields
`define CK_EN_RISE_BIT    0
`define CK_EN_FALL_BIT    1
`define CK_EN_RID_BIT     5
`define CK_EN_MASK        8'h23
`define CK_EN_RESET       8'h00

// Status register fields
`define CK_ST_OPEN_BIT    0
`define CK_ST_CODE_LSB    3
`define CK_ST_CODE_MSB    5
`define CK_ST_DONE_BIT    6

// Latch register fields
`define CK_LT_ID_BIT      0
`define CK_LT_RID_BIT     3
`define CK_LT_RESET       8'h00

// Common zero byte for unmapped reads
`define CK_BYTE_ZERO      8'h00

// Conversion timing
`define CK_CONV_TIME_NS   282000
`define CK_CLK_PERIOD_NS  40
`define CK_CONV_CYCLES    ((`CK_CONV_TIME_NS + `CK_CLK_PERIOD_NS - 1) / `CK_CLK_PERIOD_NS)
`define CK_CNT_W          13
`define CK_CNT_ZERO       13'h0000
`define CK_CNT_ONE        13'h0001

`endif

/* File: include/carkit_pkg.sv */
// Purpose: Types for the carkit ID event interrupt block
// Assumes: Constants live in carkit_defines.svh
// Notes:   Resistor code encoding and converter states
package carkit_pkg;

   // ID resistor code as reported in the status register
   typedef enum logic [2:0] {
      RID_0_OHM    = 3'h0,
      RID_75_OHM   = 3'h1,
      RID_102K_OHM = 3'h2,
      RID_200K_OHM = 3'h3,
      RID_440K_OHM = 3'h4,
      RID_FLOATING = 3'h5,
      RID_ERROR    = 3'h7
   } rid_code_t;

   // Resistor converter states
   typedef enum logic [1:0] {
      CONV_IDLE = 2'b00,
      CONV_BUSY = 2'b01
   } conv_state_t;

endpackage : carkit_pkg

/* File: rtl/bit_sync_2ff.sv */
// Purpose: Two flip-flop level synchroniser
// Assumes: Bits are independent levels or toggles
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module bit_sync_2ff #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;

   // Two stage capture
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : bit_sync_2ff

`default_nettype wire

/* File: verif/carkit_checker.sv */
// Purpose: Port assertions for the carkit event block
// Assumes: Link domain signals only
// Notes:   Bound to the design top module
`timescale 1ns/1ps
`default_nettype none
module carkit_checker
   import carkit_pkg::*;
(
   input wire logic       link_clk,
   input wire logic       link_srst,
   input wire logic [5:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_hit,
   input wire logic       vendor_rid_irq_en,
   input wire logic       vendor_code_read,
   input wire logic       resistor_conv_done,
   input wire rid_code_t  id_resistor_code,
   input wire logic       rxcmd_alt_int
);
   default clocking @(posedge link_clk); endclocking
   default disable iff (link_srst);
   a_mapped_read_hit: assert property (
      reg_rd && reg_addr inside {[6'h1d:6'h21]} |=> reg_hit) else $error("no hit");
   a_unmapped_read_zero: assert property (
      reg_rd && !(reg_addr inside {[6'h1d:6'h21]}) |=> !reg_hit && reg_rdata == 8'h00)
      else $error("unmapped read");
   a_enable_unused_zero: assert property (
      reg_rd && reg_addr inside {[6'h1d:6'h1f]} |=> (reg_rdata & 8'hdc) == 8'h00)
      else $error("enable spare bits");
   a_latch_unused_zero: assert property (
      reg_rd && reg_addr == 6'h21 |=> (reg_rdata & 8'hf6) == 8'h00)
      else $error("latch spare bits");
   a_status_layout: assert property (
      reg_rd && reg_addr == 6'h20 |=> reg_rdata[7:1] ==
         {1'b0, $past(resistor_conv_done), $past(id_resistor_code), 2'b00})
      else $error("status layout");
   a_status_keeps_done: assert property (
      reg_rd && reg_addr == 6'h20 && resistor_conv_done && !vendor_code_read
      |=> resistor_conv_done) else $error("status read cleared done");
   a_done_clear_cause: assert property (
      $fell(resistor_conv_done) |-> $past(vendor_code_read)) else $error("done fell");
   a_code_with_done: assert property (
      $changed(id_resistor_code) |-> resistor_conv_done) else $error("code without done");
   a_vendor_en_alt: assert property (
      $rose(resistor_conv_done) && vendor_rid_irq_en |-> rxcmd_alt_int)
      else $error("no alt_int on done");
   a_alt_fall_cause: assert property (
      $fell(rxcmd_alt_int) |-> $past(reg_rd || reg_wr)) else $error("alt_int dropped");
endmodule : carkit_checker
bind carkit_id_event_interrupts carkit_checker carkit_checker_inst (.link_clk, .link_srst,
   .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .reg_hit, .vendor_rid_irq_en,
   .vendor_code_read, .resistor_conv_done, .id_resistor_code, .rxcmd_alt_int);
`default_nettype wire

/* File: verif/link_model.sv */
// Purpose: Link controller model for register and conversion traffic
// Assumes: Requests start after a link clock edge
// Notes:   Idle bus lines show inverted last values
`timescale 1ns/1ps
`default_nettype none
module link_model (
   input  wire logic       link_clk,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_hit,
   output logic      [5:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic            conv_start,
   output logic            vendor_rid_irq_en,
   output logic            vendor_code_read
);
   // Idle levels
   initial begin
      reg_addr = 6'h2a;
      reg_wdata = 8'h5a;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      conv_start = 1'b0;
      vendor_rid_irq_en = 1'b0;
      vendor_code_read = 1'b0;
   end
   // One register cycle, strobe held for one taking edge
   task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q, output logic h);
      @(posedge link_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge link_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
      q = reg_rdata;
      h = reg_hit;
   endtask : xfer
   // Start pulse, or vendor code read pulse
   task automatic pulse(input logic vr);
      @(posedge link_clk);
      conv_start <= !vr;
      vendor_code_read <= vr;
      @(posedge link_clk);
      conv_start <= 1'b0;
      vendor_code_read <= 1'b0;
   endtask : pulse
endmodule : link_model
`default_nettype wire

/* File: verif/testbench.sv */
// Purpose: Self-checking bench for the carkit event block
// Assumes: Conversion shortened to 20 core cycles
// Notes:   Table of register cases, then float, conversion and reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       clk = 1'b0;
   logic       link_clk = 1'b0;
   logic       srst = 1'b1;
   logic       link_srst = 1'b1;
   logic       id_pin_open = 1'b0;
   logic [2:0] id_code_meas = 3'h0;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       reg_hit;
   logic       conv_start;
   logic       vendor_rid_irq_en;
   logic       vendor_code_read;
   logic       resistor_conv_done;
   logic       rxcmd_alt_int;
   logic [2:0] id_resistor_code;
   logic [7:0] q;
   logic       h;
   int         n;
   int         err_count = 0;
   int         comparisons = 0;
   logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
   // Rows: write addr, write data, read addr, expected read
   logic [27:0] rows [7] = '{{6'h1d, 8'hff, 6'h1d, 8'h23}, {6'h1f, 8'h01, 6'h1e, 8'h22},
      {6'h1e, 8'h01, 6'h1f, 8'h23}, {6'h21, 8'hff, 6'h21, 8'h00},
      {6'h20, 8'hff, 6'h20, 8'h00}, {6'h3f, 8'hff, 6'h3f, 8'h00},
      {6'h1d, 8'h00, 6'h1d, 8'h00}};
   always #20 clk = ~clk;
   always #7.5 link_clk = ~link_clk;
   carkit_id_event_interrupts #(.CONV_CYCLES(20)) carkit_id_event_interrupts_inst (
      .clk, .srst, .link_clk, .link_srst, .id_pin_open, .id_code_meas, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_hit, .conv_start,
      .vendor_rid_irq_en, .vendor_code_read, .resistor_conv_done,
      .id_resistor_code, .rxcmd_alt_int);
   link_model link_model_inst (.link_clk, .reg_rdata, .reg_hit, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .conv_start, .vendor_rid_irq_en, .vendor_code_read);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("mismatches %0d of %0d compares", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      link_model_inst.xfer(1'b1, a, d, q, h);
   endtask : wr
   task automatic rd(input logic [5:0] a);
      link_model_inst.xfer(1'b0, a, 8'h00, q, h);
   endtask : rd
   // Both resets held four core cycles
   task automatic do_reset;
      @(posedge clk);
      srst <= 1'b1;
      link_srst <= 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      link_srst <= 1'b0;
   endtask : do_reset
   // Move the float level, pull-up taken as on, and let it sync
   task automatic float_to(input logic v);
      @(posedge clk);
      id_pin_open <= v;
      repeat (20) @(posedge link_clk);
      #1;
   endtask : float_to
   // Hang guard
   initial begin
      #100000;
      err_count++;
      report_and_stop;
   end
   initial begin
      do_reset;
      foreach (rows[i]) begin
         wr(rows[i][27:22], rows[i][21:14]);
         rd(rows[i][13:8]);
         chk(q, rows[i][7:0]);
         chk({7'h0, h}, {7'h0, rows[i][13:8] != 6'h3f});
      end
      // Float edges against each enable
      wr(6'h1d, 8'h02);
      float_to(1'b1);
      rd(6'h20);
      chk(q, 8'h01);
      rd(6'h21);
      chk(q, 8'h00);
      float_to(1'b0);
      chk({7'h0, rxcmd_alt_int}, 8'h01);
      rd(6'h21);
      chk(q, 8'h01);
      rd(6'h21);
      chk(q, 8'h00);
      chk({7'h0, rxcmd_alt_int}, 8'h00);
      wr(6'h1d, 8'h01);
      float_to(1'b1);
      rd(6'h21);
      chk(q, 8'h01);
      float_to(1'b0);
      // Conversions over every code, enable own, vendor, none
      for (int i = 0; i < 7; i++) begin
         wr(6'h1d, (i % 3 == 0) ? 8'h20 : 8'h00);
         chk({7'h0, resistor_conv_done}, 8'h00);
         link_model_inst.vendor_rid_irq_en <= (i % 3 == 1);
         @(posedge clk);
         id_code_meas <= codes[i];
         link_model_inst.pulse(1'b0);
         n = 0;
         while (resistor_conv_done !== 1'b1 && n < 200) begin
            @(posedge link_clk);
            #1;
            n++;
         end
         chk({7'h0, n >= 53 && n <= 70}, 8'h01);
         chk({5'h0, id_resistor_code}, {5'h0, codes[i]});
         chk({7'h0, rxcmd_alt_int}, {7'h0, i % 3 != 2});
         rd(6'h20);
         chk(q, {2'b01, codes[i], 3'h0});
         chk({7'h0, resistor_conv_done}, 8'h01);
         rd(6'h21);
         chk(q, (i % 3 == 2) ? 8'h00 : 8'h08);
         link_model_inst.pulse(1'b1);
      end
      // Reset in mid-run drops the enables
      wr(6'h1d, 8'h23);
      do_reset;
      rd(6'h1d);
      chk(q, 8'h00);
      report_and_stop;
   end
endmodule : testbench
`default_nettype wire
